/* File: logic/tspc_pkg.sv */
// constants for the tag configuration and protection register bank
// assumes: byte-wide serial-bus system-area port and rf command strobes
package tspc_pkg;
  // ****************************************
  // system area map
  // ****************************************
  localparam logic [11:0] TSPC_WP_LO_ADDR = 12'h800;
  localparam logic [11:0] TSPC_WP_HI_ADDR = 12'h801;
  localparam logic [11:0] TSPC_CFG_ADDR = 12'h910;
  localparam logic [11:0] TSPC_CTRL_ADDR = 12'h920;
  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int TSPC_CFG_PIN_BIT = 3;
  localparam int TSPC_CFG_DEF_BIT = 2;
  localparam int TSPC_CTRL_DONE_BIT = 7;
  localparam int TSPC_CTRL_FIELD_BIT = 1;
  localparam logic [15:0] TSPC_WP_RST = 16'h0000;
  localparam logic [7:0] TSPC_CFG_RST = 8'hf4;
  localparam logic [7:0] TSPC_CFG_HARV_MASK = 8'h07;
  localparam logic [7:0] TSPC_CFG_PIN_MASK = 8'h08;
  typedef enum logic [2:0] {
    TSPC_RF_NONE, TSPC_RF_RD_CFG, TSPC_RF_WR_HARV, TSPC_RF_WR_PIN,
    TSPC_RF_RD_CTRL, TSPC_RF_SETCLR
  } tspc_rfcmd_t;
endpackage

/* File: logic/tspc_top.sv */
// configuration, protection and rf activity pin of a dual-interface tag
// assumes: serial-bus engine gives byte strobes; rf decoder on RF_CLK
`timescale 1ns/1ps
module tspc_top import tspc_pkg::*; (
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic RF_CLK,
  input wire logic BUS_SYS_SEL,
  input wire logic BUS_WR,
  input wire logic BUS_RD,
  input wire logic [11:0] BUS_ADDR,
  input wire logic [7:0] BUS_WDATA,
  input wire logic BUS_PWD_OK,
  input wire logic BUS_WCYC_START,
  input wire logic BUS_WCYC_DONE,
  input wire logic BUS_WCYC_OK,
  output logic [7:0] BUS_RDATA,
  output logic BUS_RVALID,
  output logic [15:0] SECTOR_LOCK,
  input wire logic RF_SOF,
  input wire logic RF_CRC_RX,
  input wire logic RF_DONE,
  input wire logic RF_INVALID,
  input wire logic RF_WRITE_ACTIVE,
  input wire logic RF_FIELD_ON,
  input wire logic RF_CMD_VALID,
  input wire tspc_rfcmd_t RF_CMD,
  input wire logic [7:0] RF_CMD_DATA,
  output logic [7:0] RF_RDATA,
  output logic RF_RVALID,
  output logic RF_ACT_PIN_O,
  output logic RF_ACT_PIN_OE,
  output logic HARVEST_OE,
  output logic [1:0] SINK_LEVEL
);
  // ****************************************
  // rf domain: activity pin
  // ****************************************
  logic rf_field_s1_q, rf_field_q;
  logic rf_busy_q, rf_wip_q, pin_q;
  logic rf_pinmode_s1_q, rf_pinmode_q;
  logic rf_cmd_tgl_q;
  tspc_rfcmd_t rf_cmd_q;
  logic [7:0] rf_cmd_data_q;
  logic [7:0] cfg_q, ctrl_rd;
  logic pin_mode;
  assign pin_mode = cfg_q[TSPC_CFG_PIN_BIT];

  always_ff @(posedge RF_CLK) begin
    rf_field_s1_q <= RF_FIELD_ON;
    rf_field_q <= rf_field_s1_q;
    rf_pinmode_s1_q <= pin_mode;
    rf_pinmode_q <= rf_pinmode_s1_q;
  end

  // busy: frame start to done, or to crc when invalid
  always_ff @(posedge RF_CLK) begin
    if (!RF_FIELD_ON) begin
      rf_busy_q <= 1'b0;
    end else if (RF_SOF) begin
      rf_busy_q <= 1'b1;
    end else if (RF_DONE || (RF_CRC_RX && RF_INVALID)) begin
      rf_busy_q <= 1'b0;
    end
  end

  // rf-side writes only, so serial writes never pull the pin
  always_ff @(posedge RF_CLK) begin
    rf_wip_q <= RF_WRITE_ACTIVE && RF_FIELD_ON;
  end

  // field cut drops the pin combinationally before its register
  always_ff @(posedge RF_CLK) begin
    pin_q <= RF_FIELD_ON && (rf_pinmode_q ? RF_WRITE_ACTIVE
                                         : (rf_busy_q || RF_SOF));
  end
  assign RF_ACT_PIN_O = 1'b0;
  assign RF_ACT_PIN_OE = pin_q;

  // rf config commands cross by toggle; data held until next one
  always_ff @(posedge RF_CLK) begin
    if (RF_CMD_VALID) begin
      rf_cmd_tgl_q <= ~rf_cmd_tgl_q;
      rf_cmd_q <= RF_CMD;
      rf_cmd_data_q <= RF_CMD_DATA;
    end
  end

  // ****************************************
  // system domain
  // ****************************************
  logic tgl_s1_q, tgl_s2_q, tgl_s3_q, sfield_s1_q, sfield_q;
  logic cmd_ev;
  logic [15:0] wp_q;
  logic heen_q, done_q, init_q;
  logic [7:0] rd_q, rfrd_q;
  logic rv_q, rfv_q;

  always_ff @(posedge SYS_CLK) begin
    tgl_s1_q <= rf_cmd_tgl_q;
    tgl_s2_q <= tgl_s1_q;
    tgl_s3_q <= tgl_s2_q;
    sfield_s1_q <= rf_field_q;
    sfield_q <= sfield_s1_q;
  end
  assign cmd_ev = tgl_s2_q ^ tgl_s3_q;

  // lock field; serial writes need the password
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      wp_q <= TSPC_WP_RST;
    end else if (BUS_SYS_SEL && BUS_WR && BUS_PWD_OK) begin
      if (BUS_ADDR == TSPC_WP_LO_ADDR) begin
        wp_q[7:0] <= BUS_WDATA;
      end else if (BUS_ADDR == TSPC_WP_HI_ADDR) begin
        wp_q[15:8] <= BUS_WDATA;
      end
    end
  end
  assign SECTOR_LOCK = wp_q;

  // config byte; non-volatile store is outside, reset gives delivery value
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      cfg_q <= TSPC_CFG_RST;
    end else if (BUS_SYS_SEL && BUS_WR && BUS_ADDR == TSPC_CFG_ADDR) begin
      cfg_q <= BUS_WDATA;
    end else if (cmd_ev && rf_cmd_q == TSPC_RF_WR_HARV) begin
      cfg_q <= (cfg_q & ~TSPC_CFG_HARV_MASK) | (rf_cmd_data_q & TSPC_CFG_HARV_MASK);
    end else if (cmd_ev && rf_cmd_q == TSPC_RF_WR_PIN) begin
      cfg_q <= (cfg_q & ~TSPC_CFG_PIN_MASK) | (rf_cmd_data_q & TSPC_CFG_PIN_MASK);
    end
  end
  assign SINK_LEVEL = cfg_q[1:0];

  // harvest enable loaded from default one cycle after reset release
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      init_q <= 1'b1;
      heen_q <= 1'b0;
    end else if (init_q) begin
      init_q <= 1'b0;
      heen_q <= ~cfg_q[TSPC_CFG_DEF_BIT];
    end else if (BUS_SYS_SEL && BUS_WR && BUS_ADDR == TSPC_CTRL_ADDR) begin
      heen_q <= BUS_WDATA[0];
    end else if (cmd_ev && rf_cmd_q == TSPC_RF_SETCLR) begin
      heen_q <= rf_cmd_data_q[0];
    end
  end
  assign HARVEST_OE = heen_q;

  // completion flag; the start clears, completion loads the ok result (and wins over start)
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      done_q <= 1'b0;
    end else if (BUS_WCYC_DONE) begin
      done_q <= BUS_WCYC_OK;
    end else if (BUS_WCYC_START) begin
      done_q <= 1'b0;
    end
  end

  assign ctrl_rd = {done_q, 5'h00, sfield_q, heen_q};

  // serial read port, one cycle after the strobe
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      rd_q <= 8'h00;
      rv_q <= 1'b0;
    end else begin
      rv_q <= BUS_RD && BUS_SYS_SEL;
      if (!(BUS_RD && BUS_SYS_SEL)) begin
        rd_q <= 8'h00;
      end else if (BUS_ADDR == TSPC_WP_LO_ADDR) begin
        rd_q <= wp_q[7:0];
      end else if (BUS_ADDR == TSPC_WP_HI_ADDR) begin
        rd_q <= wp_q[15:8];
      end else if (BUS_ADDR == TSPC_CFG_ADDR) begin
        rd_q <= cfg_q;
      end else if (BUS_ADDR == TSPC_CTRL_ADDR) begin
        rd_q <= ctrl_rd;
      end else begin
        rd_q <= 8'h00;
      end
    end
  end
  assign BUS_RDATA = rd_q;
  assign BUS_RVALID = rv_q;

  // rf read answers in the system domain; flag bit 7 not meaningful over rf
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      rfrd_q <= 8'h00;
      rfv_q <= 1'b0;
    end else begin
      rfv_q <= cmd_ev && (rf_cmd_q == TSPC_RF_RD_CFG || rf_cmd_q == TSPC_RF_RD_CTRL);
      if (cmd_ev && rf_cmd_q == TSPC_RF_RD_CFG) begin
        rfrd_q <= cfg_q;
      end else if (cmd_ev && rf_cmd_q == TSPC_RF_RD_CTRL) begin
        rfrd_q <= {1'b0, 5'h00, 1'b1, heen_q};
      end
    end
  end
  assign RF_RDATA = rfrd_q;
  assign RF_RVALID = rfv_q;

  // ****************************************
  // checks
  // ****************************************
  wp_reset_a: assert property (@(posedge SYS_CLK) !RSTN |=> wp_q == 16'h0000)
    else $error("lock field not cleared");
  wp_pwd_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (BUS_WR && !BUS_PWD_OK) |=> $stable(wp_q))
    else $error("lock written without password");
  harv_out_a: assert property (@(posedge SYS_CLK) HARVEST_OE == heen_q)
    else $error("harvest enable mismatch");
  ctrl_zero_a: assert property (@(posedge SYS_CLK) ctrl_rd[6:2] == 5'h00)
    else $error("reserved control bits set");
  done_start_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (BUS_WCYC_START && !BUS_WCYC_DONE) |=> !done_q)
    else $error("completion flag not cleared");
  harv_init_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    init_q |=> heen_q == ~$past(cfg_q[TSPC_CFG_DEF_BIT]))
    else $error("harvest default wrong");
  field_drop_a: assert property (@(posedge RF_CLK) !RF_FIELD_ON |=> !pin_q)
    else $error("pin held without field");
  busy_sof_a: assert property (@(posedge RF_CLK)
    (RF_SOF && RF_FIELD_ON && !rf_pinmode_q) |=> pin_q)
    else $error("busy pin missed frame start");
  rf_field_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (rfv_q && rfrd_q[7:6] == 2'b00 && $past(rf_cmd_q) == TSPC_RF_RD_CTRL)
    |-> rfrd_q[TSPC_CTRL_FIELD_BIT])
    else $error("rf control read field bit not 1");
endmodule

/* File: tb/tspc_bus_master.sv */
// serial-bus master model for the system area
// assumes: caller waits for read answers itself
`timescale 1ns/1ps
module tspc_bus_master (
  input wire logic clk,
  output logic sel,
  output logic wr,
  output logic rd,
  output logic [11:0] addr,
  output logic [7:0] wdata
);
  // ****
  // one byte access
  // ****
  initial begin
    sel = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 12'h000;
    wdata = 8'h00;
  end
  task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    sel = 1'b1;
    wr = w;
    rd = ~w;
    addr = a;
    wdata = d;
    @(posedge clk);
    #1;
    sel = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = ~a;
    // released lines must not keep the last value
    wdata = ~d;
  endtask
endmodule

/* File: tb/tag_sysconfig_protection_tb.sv */
// bench for the tag configuration and protection bank
// assumes: tspc_pkg compiled first
`timescale 1ns/1ps
module tag_sysconfig_protection_tb;
  import tspc_pkg::*;
  logic clk = 1'b0, rfc = 1'b0, rstn = 1'b0, pwd = 1'b0, ws = 1'b0, wd = 1'b0, wok = 1'b0;
  logic sel, wr, rd, brv, rrv, ao, aoe, hoe;
  logic [11:0] addr;
  logic [7:0] wdata, brd, rrd, r, cd = 8'h00;
  logic [15:0] lock;
  logic [1:0] sink;
  logic sof = 1'b0, crc = 1'b0, dn = 1'b0, inv = 1'b0, wact = 1'b0, fon = 1'b0, cv = 1'b0;
  tspc_rfcmd_t cmd = TSPC_RF_NONE;
  logic [7:0] expq[$];
  int fails = 0, n_tests = 0;
  always #12.5 clk = ~clk;
  initial begin
    #7;
    forever #32 rfc = ~rfc;
  end
  tspc_bus_master u_bus (.clk(clk), .sel(sel), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata));
  tspc_top u_dut (.SYS_CLK(clk), .RSTN(rstn), .RF_CLK(rfc), .BUS_SYS_SEL(sel), .BUS_WR(wr),
    .BUS_RD(rd), .BUS_ADDR(addr), .BUS_WDATA(wdata), .BUS_PWD_OK(pwd), .BUS_WCYC_START(ws),
    .BUS_WCYC_DONE(wd), .BUS_WCYC_OK(wok), .BUS_RDATA(brd), .BUS_RVALID(brv),
    .SECTOR_LOCK(lock), .RF_SOF(sof), .RF_CRC_RX(crc), .RF_DONE(dn), .RF_INVALID(inv),
    .RF_WRITE_ACTIVE(wact), .RF_FIELD_ON(fon), .RF_CMD_VALID(cv), .RF_CMD(cmd),
    .RF_CMD_DATA(cd), .RF_RDATA(rrd), .RF_RVALID(rrv), .RF_ACT_PIN_O(ao),
    .RF_ACT_PIN_OE(aoe), .HARVEST_OE(hoe), .SINK_LEVEL(sink));
  // ****
  // helpers
  // ****
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic rdq(input logic [11:0] a, input logic [7:0] e);
    expq.push_back(e);
    u_bus.acc(1'b0, a, 8'h00);
  endtask
  task automatic rf(input tspc_rfcmd_t c, input logic [7:0] d);
    @(posedge rfc);
    #1;
    cv = 1'b1;
    cmd = c;
    cd = d;
    @(posedge rfc);
    #1;
    cv = 1'b0;
    cmd = TSPC_RF_NONE;
    cd = ~d;
    repeat (6) @(posedge rfc);
  endtask
  task automatic lvl(ref logic s, input logic v);
    @(posedge rfc);
    #1;
    s = v;
    repeat (4) @(posedge rfc);
  endtask
  task automatic wcyc(input logic ok);
    ws = 1'b1;
    @(posedge clk);
    #1;
    ws = 1'b0;
    wok = ok;
    wd = 1'b1;
    @(posedge clk);
    #1;
    wd = 1'b0;
  endtask
  // one note taken off the queue per cycle with an answer; serial wins if both come
  always @(posedge clk) begin
    if (brv === 1'b1 || rrv === 1'b1) chk(brv === 1'b1 ? brd : rrd, expq.pop_front());
  end
  initial begin
    #200000;
    fails++;
    complete_run;
  end
  // ****
  // scenarios
  // ****
  initial begin
    void'($urandom(32'h6dc3));
    repeat (16) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (2) @(posedge clk);
    rdq(TSPC_WP_LO_ADDR, 8'h00);
    rdq(TSPC_WP_HI_ADDR, 8'h00);
    rdq(TSPC_CFG_ADDR, TSPC_CFG_RST);
    rdq(TSPC_CTRL_ADDR, 8'h00);
    rdq(12'h900, 8'h00);
    chk({7'h00, hoe}, 8'h00);
    r = 8'($urandom()) | 8'h01;
    u_bus.acc(1'b1, TSPC_WP_HI_ADDR, r);
    rdq(TSPC_WP_HI_ADDR, 8'h00);
    pwd = 1'b1;
    u_bus.acc(1'b1, TSPC_WP_HI_ADDR, r);
    rdq(TSPC_WP_HI_ADDR, r);
    chk(lock[15:8], r);
    chk(lock[7:0], 8'h00);
    lvl(fon, 1'b1);
    u_bus.acc(1'b1, TSPC_CTRL_ADDR, 8'hff);
    rdq(TSPC_CTRL_ADDR, 8'h03);
    chk({7'h00, hoe}, 8'h01);
    rf(TSPC_RF_SETCLR, 8'h00);
    lvl(fon, 1'b0);
    expq.push_back(8'h02);
    rf(TSPC_RF_RD_CTRL, 8'h00);
    chk({7'h00, hoe}, 8'h00);
    wcyc(1'b1);
    rdq(TSPC_CTRL_ADDR, 8'h80);
    wcyc(1'b0);
    rdq(TSPC_CTRL_ADDR, 8'h00);
    r = {5'h1e, 3'($urandom())};
    u_bus.acc(1'b1, TSPC_CFG_ADDR, r);
    rdq(TSPC_CFG_ADDR, r);
    chk({6'h00, sink}, {6'h00, r[1:0]});
    rf(TSPC_RF_WR_HARV, 8'hf8);
    expq.push_back({r[7:3], 3'b000});
    rf(TSPC_RF_RD_CFG, 8'h00);
    chk({6'h00, sink}, 8'h00);
    lvl(fon, 1'b1);
    lvl(sof, 1'b1);
    lvl(sof, 1'b0);
    chk({ao, 6'h00, aoe}, 8'h01);
    lvl(dn, 1'b1);
    lvl(dn, 1'b0);
    chk({7'h00, aoe}, 8'h00);
    lvl(sof, 1'b1);
    lvl(sof, 1'b0);
    inv = 1'b1;
    lvl(crc, 1'b1);
    lvl(crc, 1'b0);
    inv = 1'b0;
    chk({7'h00, aoe}, 8'h00);
    lvl(sof, 1'b1);
    lvl(sof, 1'b0);
    lvl(fon, 1'b0);
    chk({7'h00, aoe}, 8'h00);
    lvl(fon, 1'b1);
    rf(TSPC_RF_WR_PIN, 8'h08);
    lvl(wact, 1'b1);
    chk({7'h00, aoe}, 8'h01);
    lvl(wact, 1'b0);
    chk({7'h00, aoe}, 8'h00);
    repeat (4) @(posedge clk);
    chk(8'(expq.size()), 8'h00);
    complete_run;
  end
endmodule
